/* risp_host.sv */
// two-wire bus controller driven from axi4-lite registers
`timescale 1ns/100ps
module risp_host
	import risp_pkg::*;
#(
	parameter logic [6:0] DEV_ID  = DEV_ID_DEF,
	parameter int         QTR     = QTR_CYC,
	parameter int         AW      = 8
) (
	input  wire logic          clk,
	input  wire logic          rst,
	risp_if.host               bus,
	input  wire logic          awvalid,
	output logic               awready,
	input  wire logic [AW-1:0] awaddr,
	input  wire logic          wvalid,
	output logic               wready,
	input  wire logic [31:0]   wdata,
	input  wire logic [3:0]    wstrb,
	output logic               bvalid,
	input  wire logic          bready,
	output logic [1:0]         bresp,
	input  wire logic          arvalid,
	output logic               arready,
	input  wire logic [AW-1:0] araddr,
	output logic               rvalid,
	input  wire logic          rready,
	output logic [31:0]        rdata,
	output logic [1:0]         rresp
);
	localparam int QW = $clog2(QTR + 1);

	logic [AW-1:0]   awAddr_q;
	logic            awHave_q;
	logic [31:0]     wData_q;
	logic            wStrb_q;
	logic            wHave_q;
	logic [7:0]      word_q;
	logic [7:0]      wdat_q;
	logic            isRead_q;
	logic [1:0]      cnt_q;
	logic [31:0]     rdat_q;
	logic            busy_q;
	logic            done_q;
	logic            nack_q;
	risp_hst_t       st_q;
	logic [QW-1:0]   qCnt_q;
	logic [1:0]      ph_q;
	logic [3:0]      bit_q;
	logic [1:0]      step_q;
	logic [1:0]      rxIdx_q;
	logic [7:0]      rxSh_q;
	logic            ackBit_q;
	logic [2:0]      sdaS_q;
	logic            sdaF_q;
	logic            sclOut_q;
	logic            sdaOe_q;
	logic            sdaOut_q;

	// axi write path: address and data taken in either order
	wire            awTake = awvalid & awready;
	wire            wTake  = wvalid & wready;
	wire            awH    = awHave_q | awTake;
	wire            wH     = wHave_q | wTake;
	wire            doWr   = awH & wH & ~bvalid;
	wire [AW-1:0]   wrA    = awHave_q ? awAddr_q : awaddr;
	wire [31:0]     wrD    = wHave_q ? wData_q : wdata;
	wire            wrS    = wHave_q ? wStrb_q : wstrb[0];
	wire            bNext  = doWr | (bvalid & ~bready);
	wire            awHNxt = awH & ~doWr;
	wire            wHNxt  = wH & ~doWr;
	wire            wrMap  = (wrA == AW'(REG_CTRL)) | (wrA == AW'(REG_WORD)) | (wrA == AW'(REG_WDATA))
	                       | (wrA == AW'(REG_RDATA)) | (wrA == AW'(REG_STATUS));
	wire            wrEn   = doWr & wrS;
	wire            goReq  = wrEn & (wrA == AW'(REG_CTRL)) & wrD[CTRL_GO] & ~busy_q;

	// axi read path: one beat, answered the cycle after the address
	wire            arTake = arvalid & arready;
	wire            rNext  = arTake | (rvalid & ~rready);
	wire [31:0]     status = {29'h0, nack_q, done_q, busy_q};
	wire [31:0]     rdMux  = (araddr == AW'(REG_CTRL))   ? {28'h0, cnt_q, isRead_q, 1'b0} :
	                         (araddr == AW'(REG_WORD))   ? {24'h0, word_q} :
	                         (araddr == AW'(REG_WDATA))  ? {24'h0, wdat_q} :
	                         (araddr == AW'(REG_RDATA))  ? rdat_q :
	                         (araddr == AW'(REG_STATUS)) ? status : 32'h0;
	wire            rdMap  = (araddr == AW'(REG_CTRL)) | (araddr == AW'(REG_WORD)) | (araddr == AW'(REG_WDATA))
	                       | (araddr == AW'(REG_RDATA)) | (araddr == AW'(REG_STATUS));

	// bit engine helpers; same id for dummy write and read phase
	wire       tick   = (qCnt_q == QW'(QTR - 1));
	wire       rxMode = isRead_q & (step_q == 2'h3);
	wire       lastRx = (rxIdx_q == cnt_q);
	wire [7:0] txSel  = (step_q == 2'h0) ? {DEV_ID, RW_WRITE} :
	                    (step_q == 2'h1) ? word_q :
	                    (!isRead_q)      ? wdat_q : {DEV_ID, RW_READ};
	wire       txBit  = txSel[3'(4'h7 - bit_q)];
	wire       sdaNew = (sdaS_q[1] == sdaS_q[2]) ? sdaS_q[2] : sdaF_q;

	// axi handshake registers
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
			awHave_q <= 1'b0;
			wHave_q  <= 1'b0;
			awAddr_q <= '0;
			wData_q  <= 32'h0;
			wStrb_q  <= 1'b0;
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0;
			rresp   <= RESP_OKAY;
		end
		else
		begin
			awHave_q <= awHNxt;
			wHave_q  <= wHNxt;
			awready  <= ~awHNxt & ~bNext;
			wready   <= ~wHNxt & ~bNext;
			bvalid   <= bNext;
			arready  <= ~rNext;
			rvalid   <= rNext;
			if (awTake)
				awAddr_q <= awaddr;
			if (wTake)
			begin
				wData_q <= wdata;
				wStrb_q <= wstrb[0];
			end
			if (doWr)
				bresp <= wrMap ? RESP_OKAY : RESP_SLVERR;
			if (arTake)
			begin
				rdata <= rdMux;
				rresp <= rdMap ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// order registers; writes while busy are dropped to keep the transfer stable
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			word_q   <= 8'h00;
			wdat_q   <= 8'h00;
			isRead_q <= 1'b0;
			cnt_q    <= 2'h0;
		end
		else if (wrEn && !busy_q)
		begin
			if (wrA == AW'(REG_WORD))
				word_q <= wrD[7:0];
			if (wrA == AW'(REG_WDATA))
				wdat_q <= wrD[7:0];
			if (wrA == AW'(REG_CTRL))
			begin
				isRead_q <= wrD[CTRL_READ];
				cnt_q    <= wrD[CTRL_CNT +: 2];
			end
		end
	end

	// sda sampler, three stages
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sdaS_q <= 3'h7;
			sdaF_q <= 1'b1;
		end
		else
		begin
			sdaS_q <= {sdaS_q[1:0], bus.sda};
			sdaF_q <= sdaNew;
		end
	end

	// bus sequencer: four quarter phases per bit, scl low in phases 0 and 1
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_q <= H_IDLE;
			qCnt_q <= '0;
			ph_q <= 2'h0;
			bit_q <= 4'h0;
			step_q <= 2'h0;
			rxIdx_q <= 2'h0;
			rxSh_q <= 8'h00;
			ackBit_q <= 1'b1;
			sclOut_q <= 1'b1;
			sdaOe_q <= 1'b0;
			sdaOut_q <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			nack_q <= 1'b0;
			rdat_q <= 32'h0;
		end
		else
		begin
			qCnt_q <= (st_q == H_IDLE || tick) ? '0 : qCnt_q + QW'(1);
			if (st_q != H_IDLE && tick)
				ph_q <= ph_q + 2'h1;
			case (st_q)
				H_IDLE:
				begin
					if (goReq)
					begin
						st_q <= H_START;
						ph_q <= 2'h0;
						step_q <= 2'h0;
						rxIdx_q <= 2'h0;
						busy_q <= 1'b1;
						done_q <= 1'b0;
						nack_q <= 1'b0;
						rdat_q <= 32'h0;
					end
				end
				H_START:
				begin
					if (tick)
					begin
						case (ph_q)
							2'h0: sdaOe_q <= 1'b0;
							2'h1: sclOut_q <= 1'b1;
							2'h2: sdaOe_q <= 1'b1; // sda falls with scl high
							default:
							begin
								sclOut_q <= 1'b0;
								st_q <= H_BYTE;
								bit_q <= 4'h0;
							end
						endcase
					end
				end
				H_BYTE:
				begin
					if (tick)
					begin
						case (ph_q)
							// drive data only with scl low
							2'h0: sdaOe_q <= (bit_q == 4'h8) ? (rxMode & ~lastRx) : (~rxMode & ~txBit);
							2'h1: sclOut_q <= 1'b1;
							2'h2:
							begin
								if (bit_q == 4'h8)
									ackBit_q <= sdaF_q;
								else
									rxSh_q <= {rxSh_q[6:0], sdaF_q};
							end
							default:
							begin
								sclOut_q <= 1'b0;
								bit_q <= bit_q + 4'h1;
								if (bit_q == 4'h8)
								begin
									bit_q <= 4'h0;
									if (!rxMode && ackBit_q)
									begin
										nack_q <= 1'b1;
										st_q <= H_STOP;
									end
									else if (!isRead_q)
									begin
										step_q <= step_q + 2'h1;
										if (step_q == 2'h2)
											st_q <= H_STOP;
									end
									else if (step_q != 2'h3)
									begin
										step_q <= step_q + 2'h1;
										if (step_q == 2'h1)
											st_q <= H_START;
									end
									else
									begin
										rdat_q[8 * rxIdx_q +: 8] <= rxSh_q;
										rxIdx_q <= rxIdx_q + 2'h1;
										if (lastRx)
											st_q <= H_STOP;
									end
								end
							end
						endcase
					end
				end
				H_STOP:
				begin
					if (tick)
					begin
						case (ph_q)
							2'h0: sdaOe_q <= 1'b1;
							2'h1: sclOut_q <= 1'b1;
							2'h2: sdaOe_q <= 1'b0; // sda rises with scl high
							default:
							begin
								st_q <= H_IDLE;
								busy_q <= 1'b0;
								done_q <= 1'b1;
							end
						endcase
					end
				end
				default: st_q <= H_IDLE;
			endcase
		end
	end

	assign bus.scl = sclOut_q;
	assign bus.sdaOeM = sdaOe_q;
	assign bus.sdaOutM = sdaOut_q;
endmodule : risp_host

/* risp_pkg.sv */
// shared constants and types for the two-wire rtc register port
package risp_pkg;
	// timing
	localparam int CLK_NS        = 10;
	localparam int SCL_PERIOD_NS = 2500;
	localparam int QTR_CYC       = (SCL_PERIOD_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
	localparam int PWRUP_NS      = 2000;
	localparam int PWRUP_CYC     = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
	// slave address; value is arbitrary
	localparam logic [6:0] DEV_ID_DEF = 7'h35;
	localparam logic       RW_READ    = 1'b1;
	localparam logic       RW_WRITE   = 1'b0;
	// register space of the device
	localparam logic [7:0] PTR_RESET  = 8'h00;
	localparam logic [7:0] USER_FIRST = 8'h12;
	localparam logic [7:0] USER_LAST  = 8'h19;
	localparam int         USER_BYTES = 8;
	// controller registers, byte addresses
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_WORD   = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_RDATA  = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam int CTRL_GO    = 0;
	localparam int CTRL_READ  = 1;
	localparam int CTRL_CNT   = 2;
	localparam int STAT_BUSY  = 0;
	localparam int STAT_DONE  = 1;
	localparam int STAT_NACK  = 2;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// device states, gray along the read path; slvack to wrdata flips two bits
	typedef enum logic [2:0] {
		D_IDLE = 3'h0, D_DEVID = 3'h1, D_SLVACK = 3'h3, D_WORD = 3'h2,
		D_WRDATA = 3'h6, D_RDDATA = 3'h7, D_MSTACK = 3'h5, D_IGNORE = 3'h4
	} risp_dst_t;
	// controller states
	typedef enum logic [1:0] {
		H_IDLE = 2'h0, H_START = 2'h1, H_BYTE = 2'h3, H_STOP = 2'h2
	} risp_hst_t;
endpackage : risp_pkg

/* risp_if.sv */
// two-wire bus between controller and rtc port, open-drain sda
`timescale 1ns/100ps
interface risp_if;
	logic scl;
	logic sdaOeM;
	logic sdaOutM;
	logic sdaOeD;
	logic sdaOutD;
	logic sda;

	// wired-and with pull-up: any enabled low driver wins
	assign sda = ~((sdaOeM & ~sdaOutM) | (sdaOeD & ~sdaOutD));

	modport dev (input scl, input sda, output sdaOeD, output sdaOutD);
	modport host (output scl, input sda, output sdaOeM, output sdaOutM);
endinterface : risp_if

/* risp_device.sv */
// rtc two-wire slave port with pointer and battery-backed user bytes
//
// Contract
// - bytes shift most significant bit first
// - sda moves only while scl is low
// - sda undriven after power-up
// - ignore traffic until a start condition
// - start during power-up sequence is ignored
// - stop returns the port to idle
// - transmitter releases after eight, receiver acks
// - ack matching id, word address, data
// - master acks reads; device continues on ack
// - seven-bit id then direction bit, 1 read
// - compare id only after full byte
// - word address from master or pointer
// - pointer clears to zero at power-up
// - dummy write and read use same id
// - write is id, address, one byte, stop
// - read uses restart with direction bit 1
// - master stops after last wanted byte
// - pointer increments, wraps after 19h to 00h
// - locations 12h to 19h are user storage
// - device is slave only, never drives scl
`timescale 1ns/100ps
module risp_device
	import risp_pkg::*;
#(
	parameter logic [6:0] DEV_ID       = DEV_ID_DEF,
	parameter int         PWRUP_CYCLES = PWRUP_CYC
) (
	input  wire logic       clk,
	input  wire logic       rst,
	risp_if.dev             bus,
	output logic            busy,
	output logic            wrStrobe,
	output logic [7:0]      wrAddr,
	output logic [7:0]      wrData
);
	localparam int PW = $clog2(PWRUP_CYCLES + 1);

	logic [2:0]      sclS_q;
	logic [2:0]      sdaS_q;
	logic            sclF_q;
	logic            sdaF_q;
	logic [PW-1:0]   pwrCnt_q;
	logic            pwrDone_q;
	risp_dst_t       st_q;
	risp_dst_t       nextSt_q;
	logic [2:0]      bitCnt_q;
	logic [7:0]      shRx_q;
	logic [7:0]      txSh_q;
	logic [7:0]      ptr_q;
	logic            ackOn_q;
	logic            sdaOe_q;
	logic            sdaOut_q;
	logic [7:0]      mem [USER_BYTES];

	// filtered line levels: a change counts once stages one and two agree
	wire sclNew = (sclS_q[1] == sclS_q[2]) ? sclS_q[2] : sclF_q;
	wire sdaNew = (sdaS_q[1] == sdaS_q[2]) ? sdaS_q[2] : sdaF_q;
	wire sclRise = sclNew & ~sclF_q;
	wire sclFall = ~sclNew & sclF_q;

	// sda edges with scl high are only start or stop, never data
	wire startCond = sclF_q & sclNew & sdaF_q & ~sdaNew;
	wire stopCond  = sclF_q & sclNew & ~sdaF_q & sdaNew;
	wire startOk   = startCond & pwrDone_q;

	// incoming byte completes on the eighth rising scl edge
	wire [7:0] rxByte = {shRx_q[6:0], sdaNew};
	wire       byteIn = sclRise & (bitCnt_q == 3'h7);
	wire       idMatch = (rxByte[7:1] == DEV_ID);

	// register space: only the user bytes hold data, the rest read zero
	wire       isUser = (ptr_q >= USER_FIRST) && (ptr_q <= USER_LAST);
	wire [2:0] memIdx = 3'(ptr_q - USER_FIRST);
	wire [7:0] rdByte = isUser ? mem[memIdx] : 8'h00;
	wire [7:0] ptrInc = (ptr_q == USER_LAST) ? PTR_RESET : ptr_q + 8'h01;
	wire       memWe  = (st_q == D_WRDATA) & byteIn & isUser & ~startCond & ~stopCond;

	// pin synchronisers; stage zero feeds only stage one
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sclS_q <= 3'h7;
			sdaS_q <= 3'h7;
			sclF_q <= 1'b1;
			sdaF_q <= 1'b1;
		end
		else
		begin
			sclS_q <= {sclS_q[1:0], bus.scl};
			sdaS_q <= {sdaS_q[1:0], bus.sda};
			sclF_q <= sclNew;
			sdaF_q <= sdaNew;
		end
	end

	// power-up sequence: starts seen before it ends begin nothing
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pwrCnt_q  <= '0;
			pwrDone_q <= 1'b0;
		end
		else if (!pwrDone_q)
		begin
			pwrCnt_q  <= pwrCnt_q + PW'(1);
			pwrDone_q <= (pwrCnt_q == PW'(PWRUP_CYCLES - 1));
		end
	end

	// user storage keeps its contents over reset, as a backed-up array would
	always_ff @(posedge clk)
	begin
		if (memWe)
			mem[memIdx] <= rxByte;
	end

	// protocol engine; sda changes only on falling scl, samples on rising
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_q     <= D_IDLE;
			nextSt_q <= D_IDLE;
			bitCnt_q <= 3'h0;
			shRx_q   <= 8'h00;
			txSh_q   <= 8'h00;
			ptr_q    <= PTR_RESET;
			ackOn_q  <= 1'b0;
			sdaOe_q  <= 1'b0;
			sdaOut_q <= 1'b0;
			busy     <= 1'b0;
			wrStrobe <= 1'b0;
			wrAddr   <= 8'h00;
			wrData   <= 8'h00;
		end
		else
		begin
			wrStrobe <= 1'b0;
			if (startOk)
			begin
				// a restart also lands here, keeping the pointer
				st_q     <= D_DEVID;
				bitCnt_q <= 3'h0;
				sdaOe_q  <= 1'b0;
				ackOn_q  <= 1'b0;
				busy     <= 1'b1;
			end
			else if (stopCond)
			begin
				st_q    <= D_IDLE;
				sdaOe_q <= 1'b0;
				busy    <= 1'b0;
			end
			else
			begin
				case (st_q)
					D_DEVID, D_WORD, D_WRDATA:
					begin
						if (sclRise)
						begin
							shRx_q   <= rxByte;
							bitCnt_q <= bitCnt_q + 3'h1;
							if (bitCnt_q == 3'h7)
							begin
								st_q    <= D_SLVACK;
								ackOn_q <= 1'b0;
								if (st_q == D_DEVID)
									nextSt_q <= (rxByte[0] == RW_READ) ? D_RDDATA : D_WORD;
								else if (st_q == D_WORD)
								begin
									ptr_q    <= rxByte;
									nextSt_q <= D_WRDATA;
								end
								else
								begin
									// one data byte per write, later bytes are not acked
									nextSt_q <= D_IGNORE;
									wrStrobe <= 1'b1;
									wrAddr   <= ptr_q;
									wrData   <= rxByte;
								end
								if (st_q == D_DEVID && !idMatch)
									st_q <= D_IGNORE;
							end
						end
					end
					D_SLVACK:
					begin
						if (sclFall)
						begin
							if (!ackOn_q)
							begin
								ackOn_q <= 1'b1;
								sdaOe_q <= 1'b1;
							end
							else
							begin
								ackOn_q  <= 1'b0;
								st_q     <= nextSt_q;
								bitCnt_q <= 3'h0;
								txSh_q   <= rdByte;
								sdaOe_q  <= (nextSt_q == D_RDDATA) ? ~rdByte[7] : 1'b0;
							end
						end
					end
					D_RDDATA:
					begin
						if (sclFall)
						begin
							bitCnt_q <= bitCnt_q + 3'h1;
							if (bitCnt_q == 3'h7)
							begin
								sdaOe_q <= 1'b0;
								st_q    <= D_MSTACK;
								ptr_q   <= ptrInc;
							end
							else
							begin
								txSh_q  <= {txSh_q[6:0], 1'b0};
								sdaOe_q <= ~txSh_q[6];
							end
						end
					end
					D_MSTACK:
					begin
						// no ack means the master wants no more; wait for stop
						if (sclRise)
						begin
							if (sdaNew)
								st_q <= D_IGNORE;
							else
								ackOn_q <= 1'b1;
						end
						else if (sclFall && ackOn_q)
						begin
							st_q     <= D_RDDATA;
							ackOn_q  <= 1'b0;
							bitCnt_q <= 3'h0;
							txSh_q   <= rdByte;
							sdaOe_q  <= ~rdByte[7];
						end
					end
					D_IDLE, D_IGNORE:
						sdaOe_q <= 1'b0;
					default:
						st_q <= D_IDLE;
				endcase
			end
		end
	end

	// open drain: only ever pulls low; scl is input only
	assign bus.sdaOeD  = sdaOe_q;
	assign bus.sdaOutD = sdaOut_q;
endmodule : risp_device

/* risp_assertions.sv */
// bus-side checker for the two-wire link between controller and rtc port
`timescale 1ns/100ps
module risp_assertions
	import risp_pkg::*;
#(
	parameter logic [6:0] DEV_ID       = DEV_ID_DEF,
	parameter int         PWRUP_CYCLES = PWRUP_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sdaOeM,
	input wire logic sdaOutM,
	input wire logic sdaOeD,
	input wire logic sdaOutD,
	input wire logic sda
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic       sclQ, sdaQ, inFrame, earlyFrame, rdFrame;
	logic [3:0] bitIdx;
	logic [1:0] byteIdx;
	logic [7:0] shReg;
	int         upCnt;
	// wire events seen from the pins, no filtering
	wire startEv  = sclQ & scl & sdaQ & ~sda;
	wire stopEv   = sclQ & scl & ~sdaQ & sda;
	wire sclRise  = ~sclQ & scl;
	wire ackBit   = sclRise & (bitIdx == 4'h8);
	wire hostByte = (byteIdx == 2'h0) | ~rdFrame;

	// frame tracker; byte index saturates at 3, reached by four-byte reads
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			{sclQ, sdaQ, inFrame, earlyFrame, rdFrame} <= 5'h18;
			{bitIdx, byteIdx, shReg} <= '0;
			upCnt <= 0;
		end
		else
		begin
			sclQ <= scl;
			sdaQ <= sda;
			if (upCnt < PWRUP_CYCLES)
				upCnt <= upCnt + 1;
			if (startEv)
				{inFrame, earlyFrame, rdFrame, bitIdx, byteIdx} <= {1'b1, earlyFrame | (upCnt < PWRUP_CYCLES), 7'h0};
			else if (stopEv)
				{inFrame, earlyFrame} <= 2'h0;
			else if (ackBit)
			begin
				bitIdx  <= 4'h0;
				byteIdx <= byteIdx + {1'b0, byteIdx != 2'h3};
				if (byteIdx == 2'h0)
					rdFrame <= shReg[0];
			end
			else if (sclRise)
			begin
				bitIdx <= bitIdx + 4'h1;
				shReg  <= {shReg[6:0], sda};
			end
		end
	end

	property p_dev_low_only; $changed(sdaOeD) |-> !scl; endproperty
	a_dev_low_only: assert property (p_dev_low_only) else $error("device moved sda while scl high");
	property p_open_drain; !sdaOutD && !sdaOutM; endproperty
	a_open_drain: assert property (p_open_drain) else $error("sda driven high");
	property p_quiet; sdaOeD |-> inFrame; endproperty
	a_quiet: assert property (p_quiet) else $error("device drives sda outside a frame");
	property p_powerup; earlyFrame |-> !sdaOeD; endproperty
	a_powerup: assert property (p_powerup) else $error("device answered start in power-up");
	property p_tx_release; ackBit && hostByte |-> !sdaOeM; endproperty
	a_tx_release: assert property (p_tx_release) else $error("controller held sda on ack bit");
	property p_ack; ackBit && hostByte && !earlyFrame |-> !sda; endproperty
	a_ack: assert property (p_ack) else $error("byte not acknowledged");
	property p_id; ackBit && (byteIdx == 2'h0) |-> shReg[7:1] == DEV_ID; endproperty
	a_id: assert property (p_id) else $error("wrong id in address byte");
	property p_rd_release; ackBit && rdFrame && (byteIdx != 2'h0) |-> !sdaOeD; endproperty
	a_rd_release: assert property (p_rd_release) else $error("device held sda on master ack");
endmodule : risp_assertions

/* test_rtc_i2c_slave_register_port.sv */
// self-checking bench: controller and rtc port joined over the two-wire bus
`timescale 1ns/100ps
module test_rtc_i2c_slave_register_port
	import risp_pkg::*;
;
	localparam int         PWRUP = 120;
	localparam logic [7:0] STARTS [4] = '{8'h12, 8'h16, 8'h18, 8'h19};
	logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, busy, wrStrobe;
	logic [7:0]  awaddr, araddr, wrAddr, wrData;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [31:0] wdata, rdata, rnd, rdv;
	logic [34:0] rNote;
	logic [15:0] wNote;
	logic [7:0]  mem [USER_BYTES];
	logic [1:0]  bQ [$];
	logic [34:0] rQ [$];
	logic [15:0] wQ [$];
	int          errors, checksDone;
	int          busyRises = 0;
	logic        busyQ = 1'b0;

	risp_if bus();
	risp_host #(.QTR(8)) u_risp_host(.clk, .rst, .bus(bus), .awvalid, .awready, .awaddr, .wvalid, .wready,
		.wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
	risp_device #(.PWRUP_CYCLES(PWRUP)) u_risp_device(.clk, .rst, .bus(bus), .busy, .wrStrobe, .wrAddr, .wrData);
	risp_assertions #(.DEV_ID(DEV_ID_DEF), .PWRUP_CYCLES(PWRUP)) u_risp_assertions(.clk, .rst, .scl(bus.scl),
		.sdaOeM(bus.sdaOeM), .sdaOutM(bus.sdaOutM), .sdaOeD(bus.sdaOeD), .sdaOutD(bus.sdaOutD), .sda(bus.sda));

	// 100 mhz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs

	// reference map: user bytes hold what was written, the rest reads zero
	function automatic logic [31:0] exp_rd(input logic [7:0] a, input int n);
		logic [31:0] v;
		v = '0;
		for (int k = 0; k < n; k++)
		begin
			v[8*k +: 8] = (a >= USER_FIRST && a <= USER_LAST) ? mem[a - USER_FIRST] : 8'h00;
			a = (a == USER_LAST) ? 8'h00 : a + 8'h01;
		end
		return v;
	endfunction : exp_rd

	task automatic stop_test();
		if (errors == 0 && checksDone > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test

	task automatic cmp_axi(input string n, input logic [31:0] e, input logic [31:0] s);
		checksDone++;
		if (s !== e)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : cmp_axi

	task automatic cmp_dev(input string n, input logic [7:0] e, input logic [7:0] s);
		checksDone++;
		if (s !== e)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : cmp_dev

	// write: address and data offered together, bready held until bvalid
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		bQ.push_back(r);
		@(posedge clk);
		{awvalid, wvalid, bready} <= 3'h7;
		awaddr <= a;
		wdata  <= d;
		forever
		begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
	endtask : axi_wr

	// read: the note says whether this answer is compared
	task automatic axi_rd(input logic [7:0] a, input logic c, input logic [31:0] e, input logic [1:0] r,
		output logic [31:0] d);
		rQ.push_back({c, e, r});
		@(posedge clk);
		{arvalid, rready} <= 2'h3;
		araddr <= a;
		forever
		begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		rready <= 1'b0;
	endtask : axi_rd

	// one serial transaction, polled to completion
	task automatic xfer(input logic rd, input logic [1:0] cnt, input logic [7:0] wa, input logic [7:0] wd,
		input logic [2:0] stat);
		logic [31:0] st;
		int          r0;
		r0 = busyRises;
		axi_wr(REG_WORD, {24'h0, wa}, RESP_OKAY);
		axi_wr(REG_WDATA, {24'h0, wd}, RESP_OKAY);
		if (!rd && !stat[STAT_NACK]) wQ.push_back({wa, wd});
		axi_wr(REG_CTRL, {28'h0, cnt, rd, 1'b1}, RESP_OKAY);
		st = '0;
		while (st[STAT_DONE] !== 1'b1) axi_rd(REG_STATUS, 1'b0, '0, RESP_OKAY, st);
		axi_rd(REG_STATUS, 1'b1, {29'h0, stat}, RESP_OKAY, st);
		cmp_dev("busy", 8'h00, {7'h0, busy});
		cmp_dev("busyRises", stat[STAT_NACK] ? 8'h00 : 8'h01, 8'(busyRises - r0));
	endtask : xfer

	// result watcher: each answer takes the oldest note
	always @(posedge clk)
	begin
		if (bvalid && bready) cmp_axi("bresp", {30'h0, bQ.pop_front()}, {30'h0, bresp});
		if (rvalid && rready)
		begin
			rNote = rQ.pop_front();
			if (rNote[34]) cmp_axi("rdata", rNote[33:2], rdata);
			if (rNote[34]) cmp_axi("rresp", {30'h0, rNote[1:0]}, {30'h0, rresp});
		end
		if (wrStrobe)
		begin
			wNote = (wQ.size() > 0) ? wQ.pop_front() : 16'hxxxx; // unexpected writes show up as mismatches
			cmp_dev("wrAddr", wNote[15:8], wrAddr);
			cmp_dev("wrData", wNote[7:0], wrData);
		end
		// an accepted frame raises busy once, an ignored one never
		if (busy && !busyQ) busyRises++;
		busyQ = busy;
	end

	// main sequence
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		rst = 1'b1;
		rnd = 32'h17;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		xfer(1'b0, 2'h0, USER_FIRST, 8'h5a, 3'h6);
		repeat (PWRUP) @(posedge clk);
		for (int i = 0; i < USER_BYTES; i++)
		begin
			rnd = xs(rnd);
			mem[i] = rnd[7:0];
			xfer(1'b0, 2'h0, USER_FIRST + i[7:0], mem[i], 3'h2);
		end
		rnd = xs(rnd);
		xfer(1'b0, 2'h0, 8'h01, rnd[7:0], 3'h2);
		for (int c = 0; c < 4; c++)
		begin
			xfer(1'b1, c[1:0], STARTS[c], 8'h00, 3'h2);
			axi_rd(REG_RDATA, 1'b1, exp_rd(STARTS[c], c + 1), RESP_OKAY, rdv);
		end
		rnd = xs(rnd);
		mem[1] = rnd[7:0];
		xfer(1'b0, 2'h0, 8'h13, mem[1], 3'h2);
		xfer(1'b1, 2'h1, 8'h12, 8'h00, 3'h2);
		axi_rd(REG_RDATA, 1'b1, exp_rd(8'h12, 2), RESP_OKAY, rdv);
		axi_wr(8'h20, rnd, RESP_SLVERR);
		axi_rd(8'h14, 1'b1, 32'h0, RESP_SLVERR, rdv);
		axi_rd(REG_WORD, 1'b1, 32'h12, RESP_OKAY, rdv);
		stop_test();
	end

	// hang guard, well beyond the expected run time
	initial
	begin
		#600000;
		errors++;
		stop_test();
	end
endmodule : test_rtc_i2c_slave_register_port
